// *** prcp_map.vh ***
// Constants for the paged register command port
`ifndef PRCP_MAP_VH
`define PRCP_MAP_VH
`define PRCP_CMD_RW_BIT 15
`define PRCP_PAGE_HI 14
`define PRCP_PAGE_LO 11
`define PRCP_IDX_HI 10
`define PRCP_IDX_LO 5
`define PRCP_PAGE0 4'h0
`define PRCP_PAGE1 4'h1
`define PRCP_PAGE2 4'h2
`define PRCP_LAST_IDX 6'h3f
`define PRCP_PAST_END 16'hffff
`define PRCP_ZERO16 16'h0000
`define PRCP_RES_X 6'h00
`define PRCP_RES_Y 6'h01
`define PRCP_RES_Z1 6'h02
`define PRCP_RES_Z2 6'h03
`define PRCP_RES_B1 6'h05
`define PRCP_RES_B2 6'h06
`define PRCP_RES_AUX 6'h07
`define PRCP_RES_T1 6'h09
`define PRCP_RES_T2 6'h0a
`define PRCP_P1_ADC 6'h00
`define PRCP_P1_STAT 6'h01
`define PRCP_P1_REF 6'h03
`define PRCP_P1_RST 6'h04
`define PRCP_P1_CFG 6'h05
`define PRCP_P2_AC1 6'h00
`define PRCP_P2_VOL 6'h02
`define PRCP_P2_AC2 6'h04
`define PRCP_P2_PWR 6'h05
`define PRCP_P2_AC3 6'h06
`define PRCP_P2_COEF_LO 6'h07
`define PRCP_P2_COEF_HI 6'h1a
`define PRCP_P2_PLL_LO 6'h1b
`define PRCP_P2_PLL_HI 6'h1c
`define PRCP_P2_AC4 6'h1d
`define PRCP_WORD_LAST 4'hf
`endif

// *** prcp_sync.v ***
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module prcp_sync #(
    parameter W = 3
) (
    input wire mclk,
    input wire rst_n,
    input wire [W-1:0] din,
    output wire [W-1:0] dout
);
    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= {W{1'b0}};
            s2_r <= {W{1'b0}};
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
        end
    end
    assign dout = s2_r;
endmodule // prcp_sync
`default_nettype wire

// *** prcp_top.v ***
// Paged register command port: serial slave, decoder and register pages
//
// How it works
// - Command bit 15 set requests a read
// - Bit 15 clear writes; page 14:11, index 10:5
// - Each command, read or write, loads pointer with page, index
// - Pointer steps per word, stops at page end
// - Reads past page end return all ones
// - Three pages of 16-bit registers
// - Page 0 result map; others reserved
// - Page 2 audio control map
// - Results read-only, cleared at reset
// - Finished conversion writes its result register
// - Results right-justified, top four bits zero
// - Clock idles low, data driven first edge
// - Commands only after chip select falls
// - Only pages 0 to 2 are valid
`timescale 1ns/1ns
`default_nettype none
`include "prcp_map.vh"
module prcp_top #(
    parameter RES_W = 12
) (
    input wire mclk,
    input wire rst_n,
    input wire serial_clk,
    input wire select_n,
    input wire serial_in_pin,
    output reg serial_out_pin,
    output wire serial_out_oe_n,
    input wire conv_done,
    input wire [3:0] conv_chan,
    input wire [RES_W-1:0] conv_data,
    input wire pen_down,
    input wire adc_busy,
    output reg [15:0] ctl_word,
    output reg [5:0] ctl_index,
    output reg [1:0] ctl_page,
    output reg ctl_we
);
    // ****************************************
    // Reset release and pin synchronisers
    // ****************************************
    reg rs1_r;
    reg rs2_r;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rs1_r <= 1'b0;
            rs2_r <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rs2_r <= rs1_r;
        end
    end
    wire srst_n = rs2_r;
    wire [2:0] pins_s;
    prcp_sync #(.W(3)) u_sync (
        .mclk(mclk),
        .rst_n(srst_n),
        // Select travels inverted so the cleared chain reads deselected
        .din({serial_clk, ~select_n, serial_in_pin}),
        .dout(pins_s)
    );
    wire sck_s = pins_s[2];
    wire ssn_s = ~pins_s[1];
    wire sdi_s = pins_s[0];
    reg sck_d_r;
    reg ssn_d_r;
    always @(posedge mclk or negedge srst_n) begin
        if (!srst_n) begin
            sck_d_r <= 1'b0;
            ssn_d_r <= 1'b1;
        end else begin
            sck_d_r <= sck_s;
            ssn_d_r <= ssn_s;
        end
    end
    // Mode 1: drive on rising edge, sample on falling edge
    wire sck_rise = sck_s & ~sck_d_r;
    wire sck_fall = ~sck_s & sck_d_r;
    wire ss_fall = ~ssn_s & ssn_d_r;
    assign serial_out_oe_n = ssn_s;

    // ****************************************
    // Result page
    // ****************************************
    reg [RES_W-1:0] res_r [0:15];
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : g_res
            always @(posedge mclk or negedge srst_n) begin
                if (!srst_n) begin
                    res_r[g] <= {RES_W{1'b0}};
                end else if (conv_done && conv_chan == g) begin
                    res_r[g] <= conv_data;
                end
            end
        end
    endgenerate

    // ****************************************
    // Control pages
    // ****************************************
    reg [15:0] p1_r [0:7];
    reg [15:0] p2_r [0:31];
    reg [5:0] ptr_idx_r;
    reg [3:0] ptr_page_r;
    reg ptr_end_r;
    reg rd_mode_r;
    reg cmd_phase_r;
    reg armed_r;
    reg [3:0] bit_cnt_r;
    reg [15:0] sh_in_r;
    reg [15:0] sh_out_r;
    wire [15:0] word_in = {sh_in_r[14:0], sdi_s};
    wire word_done = sck_fall && bit_cnt_r == `PRCP_WORD_LAST;
    wire page_ok = ptr_page_r <= `PRCP_PAGE2;

    function is_res;
        input [5:0] i;
        begin
            is_res = i == `PRCP_RES_X || i == `PRCP_RES_Y ||
                i == `PRCP_RES_Z1 || i == `PRCP_RES_Z2 ||
                i == `PRCP_RES_B1 || i == `PRCP_RES_B2 ||
                i == `PRCP_RES_AUX || i == `PRCP_RES_T1 ||
                i == `PRCP_RES_T2;
        end
    endfunction
    function is_p1;
        input [5:0] i;
        begin
            is_p1 = i == `PRCP_P1_ADC || i == `PRCP_P1_STAT ||
                i == `PRCP_P1_REF || i == `PRCP_P1_RST ||
                i == `PRCP_P1_CFG;
        end
    endfunction
    function is_p2;
        input [5:0] i;
        begin
            is_p2 = i == `PRCP_P2_AC1 || i == `PRCP_P2_VOL ||
                (i >= `PRCP_P2_AC2 && i <= `PRCP_P2_AC4);
        end
    endfunction

    // Read mux: status bits replace stored ones on page 1 index 0
    reg [15:0] rd_word;
    always @* begin
        rd_word = `PRCP_ZERO16;
        if (ptr_end_r || !page_ok) begin
            rd_word = `PRCP_PAST_END;
        end else if (ptr_page_r == `PRCP_PAGE0) begin
            if (is_res(ptr_idx_r)) begin
                rd_word = {{(16-RES_W){1'b0}},
                    res_r[ptr_idx_r[3:0]]};
            end
        end else if (ptr_page_r == `PRCP_PAGE1) begin
            if (ptr_idx_r == `PRCP_P1_ADC) begin
                rd_word = {pen_down, ~adc_busy,
                    p1_r[0][13:0]};
            end else if (is_p1(ptr_idx_r)) begin
                rd_word = p1_r[ptr_idx_r[2:0]];
            end
        end else begin
            if (is_p2(ptr_idx_r)) begin
                rd_word = p2_r[ptr_idx_r[4:0]];
            end
        end
    end

    // ****************************************
    // Serial engine and pointer
    // ****************************************
    always @(posedge mclk or negedge srst_n) begin
        if (!srst_n) begin
            ptr_idx_r <= 6'h00;
            ptr_page_r <= 4'h0;
            ptr_end_r <= 1'b0;
            rd_mode_r <= 1'b0;
            cmd_phase_r <= 1'b1;
            armed_r <= 1'b0;
            bit_cnt_r <= 4'h0;
            sh_in_r <= `PRCP_ZERO16;
            sh_out_r <= `PRCP_ZERO16;
            serial_out_pin <= 1'b0;
            ctl_word <= `PRCP_ZERO16;
            ctl_index <= 6'h00;
            ctl_page <= 2'b00;
            ctl_we <= 1'b0;
        end else begin
            ctl_we <= 1'b0;
            if (ss_fall) begin
                armed_r <= 1'b1;
                cmd_phase_r <= 1'b1;
                bit_cnt_r <= 4'h0;
                sh_out_r <= `PRCP_ZERO16;
            end else if (!ssn_s) begin
                if (sck_rise) begin
                    serial_out_pin <= sh_out_r[15];
                    sh_out_r <= {sh_out_r[14:0], 1'b0};
                end
                if (sck_fall) begin
                    sh_in_r <= word_in;
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                end
                if (word_done && armed_r) begin
                    if (cmd_phase_r) begin
                        cmd_phase_r <= 1'b0;
                        rd_mode_r <= word_in[`PRCP_CMD_RW_BIT];
                        ptr_page_r <= word_in[`PRCP_PAGE_HI:`PRCP_PAGE_LO];
                        ptr_idx_r <= word_in[`PRCP_IDX_HI:`PRCP_IDX_LO];
                        ptr_end_r <= 1'b0;
                        // Low five bits are ignored by design
                    end else begin
                        // Page 0 is read-only: no strobe for it
                        if (!rd_mode_r && !ptr_end_r && page_ok &&
                            ptr_page_r != `PRCP_PAGE0) begin
                            ctl_word <= word_in;
                            ctl_index <= ptr_idx_r;
                            ctl_page <= ptr_page_r[1:0];
                            ctl_we <= 1'b1;
                        end
                        if (ptr_idx_r == `PRCP_LAST_IDX) begin
                            ptr_end_r <= 1'b1;
                        end else begin
                            ptr_idx_r <= ptr_idx_r + 6'h01;
                        end
                    end
                end
            end else begin
                armed_r <= 1'b0;
            end
            // Load next read word once pointer has settled
            if (!ssn_s && armed_r && !cmd_phase_r && rd_mode_r &&
                bit_cnt_r == 4'h0 && !sck_s && sck_d_r == 1'b0) begin
                sh_out_r <= rd_word;
            end
        end
    end

    // Page 1 and 2 storage; page 0 writes are dropped as read-only
    integer k;
    always @(posedge mclk or negedge srst_n) begin
        if (!srst_n) begin
            for (k = 0; k < 8; k = k + 1) begin
                p1_r[k] <= `PRCP_ZERO16;
            end
            for (k = 0; k < 32; k = k + 1) begin
                p2_r[k] <= `PRCP_ZERO16;
            end
        end else if (ctl_we) begin
            if (ctl_page == `PRCP_PAGE1 && is_p1(ctl_index)) begin
                p1_r[ctl_index[2:0]] <= ctl_word;
            end
            if (ctl_page == `PRCP_PAGE2 && is_p2(ctl_index)) begin
                p2_r[ctl_index[4:0]] <= ctl_word;
            end
        end
    end
endmodule // prcp_top
`default_nettype wire

// *** prcp_asserts.sv ***
// Pin-level assertions for the paged register command port
`timescale 1ns/1ns
`default_nettype none
module prcp_asserts #(
    parameter RES_W = 12
) (
    input wire mclk,
    input wire rst_n,
    input wire serial_clk,
    input wire select_n,
    input wire serial_in_pin,
    input wire serial_out_pin,
    input wire serial_out_oe_n,
    input wire conv_done,
    input wire [3:0] conv_chan,
    input wire [RES_W-1:0] conv_data,
    input wire pen_down,
    input wire adc_busy,
    input wire [15:0] ctl_word,
    input wire [5:0] ctl_index,
    input wire [1:0] ctl_page,
    input wire ctl_we
);
// ****************************************
// Properties
// ****************************************
default clocking cb @(posedge mclk); endclocking
default disable iff (!rst_n);
logic seen_r;
logic [5:0] last_idx_r;
// Index only has to grow: refused words may leave holes
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        seen_r <= 1'b0;
        last_idx_r <= 6'h00;
    end else if (ctl_we) begin
        seen_r <= 1'b1;
        last_idx_r <= ctl_index;
    end else if (select_n) begin
        seen_r <= 1'b0;
    end
end
property p_we_pulse; ctl_we |=> !ctl_we [*8]; endproperty
a_we_pulse: assert property (p_we_pulse) else $error("strobe long");
property p_we_page; ctl_we |-> ctl_page inside {2'd1, 2'd2}; endproperty
a_we_page: assert property (p_we_page) else $error("bad page");
property p_we_step; ctl_we && seen_r |-> ctl_index > last_idx_r; endproperty
a_we_step: assert property (p_we_step) else $error("no step");
property p_we_sel; ctl_we |-> !$past(select_n, 8); endproperty
a_we_sel: assert property (p_we_sel) else $error("unframed");
property p_idle_oe; select_n [*8] |-> serial_out_oe_n; endproperty
a_idle_oe: assert property (p_idle_oe) else $error("drives idle");
property p_sel_oe; !select_n [*6] |-> !serial_out_oe_n; endproperty
a_sel_oe: assert property (p_sel_oe) else $error("not driving");
property p_hold; (!serial_clk && !select_n) [*6] |-> $stable(serial_out_pin);
endproperty
a_hold: assert property (p_hold) else $error("out moved low");
property p_idle_we; select_n [*8] |-> !ctl_we; endproperty
a_idle_we: assert property (p_idle_we) else $error("idle write");
endmodule // prcp_asserts
`default_nettype wire

// *** prcp_host.sv ***
// Behavioural serial host that frames commands and data words
`timescale 1ns/1ns
`default_nettype none
module prcp_host (
    output logic serial_clk,
    output logic select_n,
    output logic serial_in_pin,
    input wire serial_out_pin,
    input wire serial_out_oe_n
);
// ****************************************
// Framing
// ****************************************
logic [15:0] tx [0:15];
logic [15:0] rx [0:15];
int gap = 0;
initial begin
    serial_clk = 1'b0;
    select_n = 1'b1;
    serial_in_pin = 1'b0;
end
task automatic word(input logic [15:0] w, output logic [15:0] r);
    for (int b = 15; b >= 0; b--) begin
        serial_clk = 1'b1;
        serial_in_pin = w[b];
        #160;
        r[b] = serial_out_oe_n ? ~serial_out_pin : serial_out_pin;
        serial_clk = 1'b0;
        #(160 + gap);
    end
endtask
task automatic frame(input logic [15:0] cmd, input int n);
    logic [15:0] junk;
    select_n = 1'b0;
    #333;
    word(cmd, junk);
    for (int i = 0; i < n; i++) word(tx[i], rx[i]);
    select_n = 1'b1;
    // Released line shows the opposite level, not a stale one
    serial_in_pin = ~serial_in_pin;
    #707;
endtask
endmodule // prcp_host
`default_nettype wire

// *** prcp_top_tb.sv ***
// Self-checking bench for the paged register command port
`timescale 1ns/1ns
`default_nettype none
module prcp_top_tb;
// ****************************************
// Bench
// ****************************************
logic mclk, rst_n, conv_done, pen_down, adc_busy, ctl_we;
logic serial_clk, select_n, serial_in_pin, serial_out_pin, serial_out_oe_n;
logic [3:0] conv_chan;
logic [11:0] conv_data;
logic [15:0] ctl_word;
logic [5:0] ctl_index;
logic [1:0] ctl_page;
logic [23:0] we_log [0:7];
int err_count, comparisons, we_n, i;
prcp_top #(.RES_W(12)) i_prcp_top (.mclk(mclk), .rst_n(rst_n),
    .serial_clk(serial_clk), .select_n(select_n),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .serial_out_oe_n(serial_out_oe_n), .conv_done(conv_done),
    .conv_chan(conv_chan), .conv_data(conv_data), .pen_down(pen_down),
    .adc_busy(adc_busy), .ctl_word(ctl_word), .ctl_index(ctl_index),
    .ctl_page(ctl_page), .ctl_we(ctl_we));
prcp_host host (.serial_clk(serial_clk), .select_n(select_n),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .serial_out_oe_n(serial_out_oe_n));
initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
end
always @(posedge mclk) begin
    if (ctl_we === 1'b1 && we_n < 8) begin
        we_log[we_n] = {ctl_page, ctl_index, ctl_word};
        we_n++;
    end
end
task chk(input logic [23:0] got, input logic [23:0] exp_v);
    comparisons++;
    if (got !== exp_v) begin
        err_count++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp_v);
    end
endtask
task conv(input logic [3:0] ch, input logic [11:0] v);
    @(posedge mclk) #2;
    conv_chan = ch;
    conv_data = v;
    conv_done = 1'b1;
    @(posedge mclk) #2;
    conv_done = 1'b0;
endtask
task give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
endtask
initial begin
    #3000000;
    err_count++;
    give_verdict;
end
initial begin
    rst_n = 1'b0;
    conv_done = 1'b0;
    conv_chan = 4'h0;
    conv_data = 12'h000;
    pen_down = 1'b1;
    adc_busy = 1'b0;
    err_count = 0;
    comparisons = 0;
    we_n = 0;
    repeat (12) @(posedge mclk);
    #2 rst_n = 1'b1;
    repeat (8) @(posedge mclk);
    host.frame(16'h8000, 11);
    for (i = 0; i < 11; i++) chk({8'h00, host.rx[i]}, 24'h0);
    $display("test reset values done");
    for (i = 0; i < 11; i++) if (i != 4 && i != 8) conv(i[3:0], 12'hff0 ^ i[11:0]);
    host.frame(16'h8000, 11);
    for (i = 0; i < 11; i++) chk({8'h00, host.rx[i]}, (i == 4 || i == 8) ?
        24'h0 : {12'h000, 12'hff0 ^ i[11:0]});
    $display("test results done");
    host.gap = 300;
    host.frame(16'h87c0, 4);
    host.gap = 0;
    for (i = 0; i < 4; i++) chk({8'h00, host.rx[i]}, i < 2 ? 24'h0 : 24'hffff);
    $display("test page end done");
    host.tx[0] = 16'h1234;
    host.tx[1] = 16'h0a5a;
    host.frame(16'h0800, 2);
    host.tx[0] = 16'hbeef;
    host.frame(16'h13a0, 1);
    host.frame(16'h0000, 1);
    host.frame(16'h1800, 1);
    chk(we_n[23:0], 24'h3);
    chk(we_log[0], 24'h401234);
    chk(we_log[1], 24'h410a5a);
    chk(we_log[2], 24'h9dbeef);
    $display("test writes done");
    host.frame(16'h8800, 1);
    chk({22'h0, host.rx[0][15:14]}, 24'h3);
    @(posedge mclk) #2;
    pen_down = 1'b0;
    adc_busy = 1'b1;
    host.frame(16'h8800, 1);
    chk({22'h0, host.rx[0][15:14]}, 24'h0);
    $display("test status done");
    host.frame(16'hb800, 2);
    chk({8'h00, host.rx[1]}, 24'hffff);
    host.frame(16'h8000, 1);
    chk({8'h00, host.rx[0]}, 24'h000ff0);
    $display("test bad page done");
    give_verdict;
end
endmodule // prcp_top_tb
bind prcp_top prcp_asserts #(.RES_W(RES_W)) u_chk (.mclk(mclk), .rst_n(rst_n),
    .serial_clk(serial_clk), .select_n(select_n),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .serial_out_oe_n(serial_out_oe_n), .conv_done(conv_done),
    .conv_chan(conv_chan), .conv_data(conv_data), .pen_down(pen_down),
    .adc_busy(adc_busy), .ctl_word(ctl_word), .ctl_index(ctl_index),
    .ctl_page(ctl_page), .ctl_we(ctl_we));
`default_nettype wire
